// ==== rtl/bac_pkg.sv ====
package bac_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register geometry
    localparam int unsigned REG_W    = 8;
    localparam int unsigned NUM_REGS = 11;
    localparam int unsigned SLOT_W   = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DC_THR      = 8'h50;
    localparam logic [7:0] IDX_PRE_LEAD    = 8'h52;
    localparam logic [7:0] IDX_PRE_LAG     = 8'h54;
    localparam logic [7:0] IDX_PAY_LEAD    = 8'h56;
    localparam logic [7:0] IDX_PAY_LAG     = 8'h58;
    localparam logic [7:0] IDX_FAR_TARGET  = 8'h5a;
    localparam logic [7:0] IDX_ACQ_TLINE   = 8'h5c;
    localparam logic [7:0] IDX_ACQ_THR     = 8'h5e;
    localparam logic [7:0] IDX_LONG_SEED   = 8'h60;
    localparam logic [7:0] IDX_SHORT_SEED  = 8'h62;
    localparam logic [7:0] IDX_RX_CFG_FIVE = 8'h64;

    // storage slots
    localparam logic [SLOT_W-1:0] SLOT_DC_THR      = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_PRE_LEAD    = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_PRE_LAG     = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_PAY_LEAD    = 4'h3;
    localparam logic [SLOT_W-1:0] SLOT_PAY_LAG     = 4'h4;
    localparam logic [SLOT_W-1:0] SLOT_FAR_TARGET  = 4'h5;
    localparam logic [SLOT_W-1:0] SLOT_ACQ_TLINE   = 4'h6;
    localparam logic [SLOT_W-1:0] SLOT_ACQ_THR     = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_LONG_SEED   = 4'h8;
    localparam logic [SLOT_W-1:0] SLOT_SHORT_SEED  = 4'h9;
    localparam logic [SLOT_W-1:0] SLOT_RX_CFG_FIVE = 4'ha;
    localparam logic [SLOT_W-1:0] SLOT_NONE        = 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // field layout and reset values
    localparam int unsigned THR_W         = 6;
    localparam int unsigned SEED_W        = 7;
    localparam int unsigned BIT_LONG_DIS  = 7;
    localparam int unsigned BIT_DIV_RSSI  = 6;
    localparam int unsigned BIT_FAR_DIS   = 7;
    localparam int unsigned BIT_ED_AND_SQ = 6;
    localparam int unsigned BIT_RO_SEL    = 7;
    localparam int unsigned BIT_SEED_SEL  = 3;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [5:0]  THR_MAX       = 6'h3f;

    // false alarm target: allowed alarms per window = n * scale
    localparam int unsigned FAR_SCALE     = 32;
    localparam int unsigned FAR_WINDOW    = 65536;
    localparam int unsigned FAR_CNT_W     = 17;

    // ahb-lite
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;

endpackage : bac_pkg

// ==== rtl/bac_acq_detect.sv ====
`timescale 1ns/100ps
`default_nettype none

module bac_acq_detect
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // metrics
    input  wire logic [5:0] signal_quality_metric,
    input  wire logic       energy_detect_flag,
    // settings
    input  wire logic [5:0] detect_thr,
    input  wire logic [5:0] verify_thr,
    input  wire logic       ed_and_sq,
    // results
    output logic            acq_detect_r,
    output logic            verify_pass_r
);

    ////////////////////////////////////////////////////////////////////////////
    // both thresholds share the 3.3 fixed point format of the metric
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            acq_detect_r <= 1'b0;
        else
            acq_detect_r <= (signal_quality_metric >= detect_thr) &&
                            (!ed_and_sq || energy_detect_flag);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            verify_pass_r <= 1'b0;
        else
            verify_pass_r <= signal_quality_metric >= verify_thr;
    end

endmodule : bac_acq_detect

`default_nettype wire

// ==== rtl/bac_far_adapt.sv ====
`timescale 1ns/100ps
`default_nettype none

module bac_far_adapt
#(
    parameter int unsigned WINDOW = bac_pkg::FAR_WINDOW
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // events
    input  wire logic       sample_tick,
    input  wire logic       false_alarm,
    // settings
    input  wire logic [7:0] target,
    input  wire logic [5:0] init_thr,
    input  wire logic       far_disable,
    input  wire logic       init_load,
    // adapted threshold
    output logic [5:0]      thr_r
);

    localparam int unsigned CW = bac_pkg::FAR_CNT_W;

    logic [CW-1:0] win_cnt_r;
    logic [CW-1:0] alarm_cnt_r;
    logic [CW-1:0] allowed;
    logic          win_end;

    assign allowed = CW'(target) * CW'(bac_pkg::FAR_SCALE);
    assign win_end = sample_tick && (win_cnt_r == CW'(WINDOW - 1));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            win_cnt_r <= '0;
        else if (win_end)
            win_cnt_r <= '0;
        else if (sample_tick)
            win_cnt_r <= win_cnt_r + 1'b1;
    end

    // saturates so a noisy window cannot wrap back to low
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            alarm_cnt_r <= '0;
        else if (win_end)
            alarm_cnt_r <= '0;
        else if (false_alarm && alarm_cnt_r != '1)
            alarm_cnt_r <= alarm_cnt_r + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            thr_r <= bac_pkg::REG_RESET[5:0];
        else if (far_disable || init_load)
            thr_r <= init_thr;
        else if (win_end && alarm_cnt_r > allowed && thr_r != bac_pkg::THR_MAX)
            thr_r <= thr_r + 1'b1;
        else if (win_end && alarm_cnt_r < allowed && thr_r != 6'h00)
            thr_r <= thr_r - 1'b1;
    end

endmodule : bac_far_adapt

`default_nettype wire

// ==== rtl/bac_regs.sv ====
// Functional notes
// - dc offset compensation runs only while rssi exceeds the 6-bit threshold plus noise floor.
// - during preamble and header the carrier loop uses the preamble lead and lag coefficients.
// - during payload the carrier loop uses the separate payload lead and lag coefficients.
// - the 8-bit false alarm target n means a rate of n times 32 over 2 to the 16th.
// - timeline disable at one treats every preamble as short; at zero long handling runs.
// - long timeline antenna choice uses h factors at zero and rssi at one.
// - the verify cycle compares signal quality with the second 3.3 fixed point threshold.
// - the first threshold drives initial detect and seeds the false alarm adaptation.
// - with the far disable bit clear the first threshold adapts, set it holds the field.
// - acquisition needs signal quality only at zero, energy detect and quality at one.
// - a 7-bit seed is held for long preamble frames.
// - a second 7-bit seed for short preamble frames shares its register with readback select.
// - bit 3 of the rx config five register picks which seed the scrambler loads.
// - status registers show the second set when the select bit is zero, the first when one.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module bac_regs
#(
    parameter int unsigned FAR_WINDOW = bac_pkg::FAR_WINDOW
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // baseband measurements
    input  wire logic [7:0]  rssi,
    input  wire logic [7:0]  noise_floor,
    input  wire logic        payload_phase,
    input  wire logic [5:0]  signal_quality_metric,
    input  wire logic        energy_detect_flag,
    input  wire logic        sample_tick,
    input  wire logic        false_alarm_pulse,
    // baseband controls
    output logic             dc_comp_en,
    output logic [5:0]       loop_lead_coeff,
    output logic [5:0]       loop_lag_coeff,
    output logic [5:0]       detect_threshold,
    output logic             acq_detect,
    output logic             verify_pass,
    output logic             long_preamble_en,
    output logic             diversity_by_rssi,
    output logic [6:0]       scrambler_seed,
    output logic             status_show_first
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic [bac_pkg::SLOT_W-1:0] slot_of(input logic [31:0] addr);
        logic [bac_pkg::SLOT_W-1:0] s;
        s = bac_pkg::SLOT_NONE;
        if (addr[1:0] == 2'b00 && addr[31:10] == 22'h00_0000)
        begin
            unique case (addr[9:2])
                bac_pkg::IDX_DC_THR:      s = bac_pkg::SLOT_DC_THR;
                bac_pkg::IDX_PRE_LEAD:    s = bac_pkg::SLOT_PRE_LEAD;
                bac_pkg::IDX_PRE_LAG:     s = bac_pkg::SLOT_PRE_LAG;
                bac_pkg::IDX_PAY_LEAD:    s = bac_pkg::SLOT_PAY_LEAD;
                bac_pkg::IDX_PAY_LAG:     s = bac_pkg::SLOT_PAY_LAG;
                bac_pkg::IDX_FAR_TARGET:  s = bac_pkg::SLOT_FAR_TARGET;
                bac_pkg::IDX_ACQ_TLINE:   s = bac_pkg::SLOT_ACQ_TLINE;
                bac_pkg::IDX_ACQ_THR:     s = bac_pkg::SLOT_ACQ_THR;
                bac_pkg::IDX_LONG_SEED:   s = bac_pkg::SLOT_LONG_SEED;
                bac_pkg::IDX_SHORT_SEED:  s = bac_pkg::SLOT_SHORT_SEED;
                bac_pkg::IDX_RX_CFG_FIVE: s = bac_pkg::SLOT_RX_CFG_FIVE;
                default:                  s = bac_pkg::SLOT_NONE;
            endcase
        end
        return s;
    endfunction : slot_of

    ////////////////////////////////////////////////////////////////////////////
    // bus state
    logic                        addr_take;
    logic [bac_pkg::SLOT_W-1:0]  addr_slot;
    logic                        wr_pend_r;
    logic [bac_pkg::SLOT_W-1:0]  wr_slot_r;
    logic [7:0]                  regs_r [bac_pkg::NUM_REGS];
    logic [7:0]                  rd_val;
    logic                        far_init_load;
    logic [5:0]                  far_thr;

    assign addr_take = hsel && hready && htrans == bac_pkg::HTRANS_NONSEQ;
    assign addr_slot = slot_of(haddr);

    // zero wait state slave; response is always okay
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // only whole-word writes to a mapped slot are kept
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_pend_r <= 1'b0;
            wr_slot_r <= bac_pkg::SLOT_NONE;
        end
        else
        begin
            wr_pend_r <= addr_take && hwrite && hsize == bac_pkg::HSIZE_WORD &&
                         addr_slot != bac_pkg::SLOT_NONE;
            wr_slot_r <= addr_slot;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage; upper bits are stored even though unused
    generate
        for (genvar i = 0; i < bac_pkg::NUM_REGS; i++)
        begin : g_reg
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    regs_r[i] <= bac_pkg::REG_RESET;
                else if (wr_pend_r && wr_slot_r == bac_pkg::SLOT_W'(i))
                    regs_r[i] <= hwdata[7:0];
            end
        end
    endgenerate

    // read data sampled in the address phase; forwards a write still in
    // its data phase so back to back write then read returns the new value
    always_comb
    begin
        rd_val = 8'h00;
        if (addr_slot != bac_pkg::SLOT_NONE)
        begin
            if (wr_pend_r && wr_slot_r == addr_slot)
                rd_val = hwdata[7:0];
            else
                rd_val = regs_r[addr_slot];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (addr_take && !hwrite)
            hrdata <= {24'h00_0000, rd_val};
    end

    ////////////////////////////////////////////////////////////////////////////
    // dc offset compensation gate
    logic [8:0] dc_level;

    assign dc_level = 9'(regs_r[bac_pkg::SLOT_DC_THR][5:0]) + 9'(noise_floor);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            dc_comp_en <= 1'b0;
        else
            dc_comp_en <= 9'(rssi) > dc_level;
    end

    ////////////////////////////////////////////////////////////////////////////
    // carrier loop coefficients; only the 6-bit fields reach the loop
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            loop_lead_coeff <= bac_pkg::REG_RESET[5:0];
            loop_lag_coeff  <= bac_pkg::REG_RESET[5:0];
        end
        else if (payload_phase)
        begin
            loop_lead_coeff <= regs_r[bac_pkg::SLOT_PAY_LEAD][5:0];
            loop_lag_coeff  <= regs_r[bac_pkg::SLOT_PAY_LAG][5:0];
        end
        else
        begin
            loop_lead_coeff <= regs_r[bac_pkg::SLOT_PRE_LEAD][5:0];
            loop_lag_coeff  <= regs_r[bac_pkg::SLOT_PRE_LAG][5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // long preamble timeline controls
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            long_preamble_en  <= 1'b0;
            diversity_by_rssi <= 1'b0;
        end
        else
        begin
            long_preamble_en  <= !regs_r[bac_pkg::SLOT_ACQ_TLINE][bac_pkg::BIT_LONG_DIS];
            diversity_by_rssi <= regs_r[bac_pkg::SLOT_ACQ_TLINE][bac_pkg::BIT_DIV_RSSI];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // false alarm adaptation of the first threshold
    // a fresh write restarts adaptation; the field is still old then, so take the bus data
    assign far_init_load = wr_pend_r && wr_slot_r == bac_pkg::SLOT_ACQ_THR;

    bac_far_adapt
    #(
        .WINDOW      (FAR_WINDOW)
    )
    u_far
    (
        .clk         (clk),
        .rst_n       (rst_n),
        .sample_tick (sample_tick),
        .false_alarm (false_alarm_pulse),
        .target      (regs_r[bac_pkg::SLOT_FAR_TARGET]),
        .init_thr    (far_init_load ? hwdata[5:0] : regs_r[bac_pkg::SLOT_ACQ_THR][5:0]),
        .far_disable (regs_r[bac_pkg::SLOT_ACQ_THR][bac_pkg::BIT_FAR_DIS]),
        .init_load   (far_init_load),
        .thr_r       (far_thr)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            detect_threshold <= bac_pkg::REG_RESET[5:0];
        else
            detect_threshold <= far_thr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // acquisition detect and verify
    bac_acq_detect u_acq
    (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .signal_quality_metric (signal_quality_metric),
        .energy_detect_flag    (energy_detect_flag),
        .detect_thr            (far_thr),
        .verify_thr            (regs_r[bac_pkg::SLOT_ACQ_TLINE][5:0]),
        .ed_and_sq             (regs_r[bac_pkg::SLOT_ACQ_THR][bac_pkg::BIT_ED_AND_SQ]),
        .acq_detect_r          (acq_detect),
        .verify_pass_r         (verify_pass)
    );

    ////////////////////////////////////////////////////////////////////////////
    // scrambler seed and status readback select
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            scrambler_seed <= bac_pkg::REG_RESET[6:0];
        else if (regs_r[bac_pkg::SLOT_RX_CFG_FIVE][bac_pkg::BIT_SEED_SEL])
            scrambler_seed <= regs_r[bac_pkg::SLOT_SHORT_SEED][6:0];
        else
            scrambler_seed <= regs_r[bac_pkg::SLOT_LONG_SEED][6:0];
    end

    // status mux lives outside; one means the first value set
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            status_show_first <= 1'b0;
        else
            status_show_first <= regs_r[bac_pkg::SLOT_SHORT_SEED][bac_pkg::BIT_RO_SEL];
    end

endmodule : bac_regs

`default_nettype wire

// ==== verification/bac_regs_chk.sv ====
`timescale 1ns/100ps
`default_nettype none

module bac_regs_chk
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // ahb-lite slave
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // baseband side
    input wire logic [7:0]  rssi,
    input wire logic [7:0]  noise_floor,
    input wire logic        payload_phase,
    input wire logic [5:0]  signal_quality_metric,
    input wire logic        energy_detect_flag,
    input wire logic        dc_comp_en,
    input wire logic [5:0]  loop_lead_coeff,
    input wire logic [5:0]  loop_lag_coeff,
    input wire logic [5:0]  detect_threshold,
    input wire logic        acq_detect,
    input wire logic        verify_pass,
    input wire logic        long_preamble_en,
    input wire logic        diversity_by_rssi,
    input wire logic [6:0]  scrambler_seed,
    input wire logic        status_show_first
);

    ////////////////////////////////////////////////////////////////////////////
    // shadow of the register file, so checks need no hierarchy
    logic [7:0]      sh [0:15];
    logic            wp_r;
    logic [3:0]      ws_r;
    wire logic [7:0] ix   = haddr[9:2];
    wire logic [7:0] off  = ix - bac_pkg::IDX_DC_THR;
    wire logic       map  = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0 && ix >= 8'h50
                            && ix <= 8'h64 && !ix[0];
    wire logic       tk   = hsel && hready && htrans == bac_pkg::HTRANS_NONSEQ;
    // a write in its data phase lands at the same edge a read is taken
    wire logic [7:0] rx   = !map ? 8'h00 : (wp_r && ws_r == off[4:1]) ? hwdata[7:0] : sh[off[4:1]];
    wire logic [7:0] dc_v = sh[0];
    wire logic [7:0] pl_v = sh[1];
    wire logic [7:0] pg_v = sh[2];
    wire logic [7:0] yl_v = sh[3];
    wire logic [7:0] yg_v = sh[4];
    wire logic [7:0] tl_v = sh[6];
    wire logic [7:0] aq_v = sh[7];
    wire logic [7:0] ls_v = sh[8];
    wire logic [7:0] ss_v = sh[9];
    wire logic [7:0] c5_v = sh[10];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wp_r <= 1'b0;
        else
            wp_r <= tk && hwrite && map && hsize == bac_pkg::HSIZE_WORD;
        ws_r <= off[4:1];
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 16; i++)
            if (!rst_n)
                sh[i] <= 8'h00;
            else if (wp_r && ws_r == 4'(i))
                sh[i] <= hwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd_taken;
        tk && !hwrite;
    endsequence

    // far logic off and field untouched long enough for the load to land
    sequence s_far_held;
        (aq_v[7] && $stable(aq_v)) [*6];
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_read_data: assert property (s_rd_taken |=> hrdata == {24'h0, $past(rx)})
        else $error("read data differs from last write");
    a_dc_gate: assert property ($past(rst_n) |-> dc_comp_en ==
        ({1'b0, $past(rssi)} > {3'h0, $past(dc_v[5:0])} + {1'b0, $past(noise_floor)}))
        else $error("dc compensation enable wrong");
    a_loop_coeff: assert property ($past(rst_n) |->
        loop_lead_coeff == ($past(payload_phase) ? $past(yl_v[5:0]) : $past(pl_v[5:0]))
        && loop_lag_coeff == ($past(payload_phase) ? $past(yg_v[5:0]) : $past(pg_v[5:0])))
        else $error("loop coefficient pair wrong");
    a_timeline_bits: assert property ($past(rst_n) |->
        long_preamble_en == !$past(tl_v[7]) && diversity_by_rssi == $past(tl_v[6]))
        else $error("timeline controls wrong");
    a_verify_cmp: assert property ($past(rst_n) |->
        verify_pass == ($past(signal_quality_metric) >= $past(tl_v[5:0])))
        else $error("verify result wrong");
    a_far_hold: assert property (s_far_held |-> detect_threshold == aq_v[5:0])
        else $error("held threshold differs from field");
    a_acq_gate: assert property (s_far_held |-> acq_detect ==
        ($past(signal_quality_metric) >= aq_v[5:0] && (!aq_v[6] || $past(energy_detect_flag))))
        else $error("acquisition trigger wrong");
    a_seed_pick: assert property ($past(rst_n) |->
        scrambler_seed == ($past(c5_v[3]) ? $past(ss_v[6:0]) : $past(ls_v[6:0])))
        else $error("scrambler seed wrong");
    a_status_sel: assert property ($past(rst_n) |-> status_show_first == $past(ss_v[7]))
        else $error("status set select wrong");

endmodule : bac_regs_chk

bind bac_regs bac_regs_chk i_chk
(
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .rssi, .noise_floor, .payload_phase, .signal_quality_metric,
    .energy_detect_flag, .dc_comp_en, .loop_lead_coeff, .loop_lag_coeff, .detect_threshold,
    .acq_detect, .verify_pass, .long_preamble_en, .diversity_by_rssi, .scrambler_seed,
    .status_show_first
);

`default_nettype wire

// ==== verification/test_bac_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_bac_regs;
    // short window keeps the adaptive runs brief
    localparam int WIN = 64;
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, payload_phase;
    logic        energy_detect_flag, sample_tick, false_alarm_pulse, dc_comp_en, acq_detect;
    logic        verify_pass, long_preamble_en, diversity_by_rssi, status_show_first;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [7:0]  rssi, noise_floor;
    logic [6:0]  scrambler_seed;
    logic [5:0]  signal_quality_metric, loop_lead_coeff, loop_lag_coeff, detect_threshold;
    logic [2:0]  hsize;
    logic [1:0]  htrans, m;
    int          err_count, checks;
    int          na [4] = '{40, 0, 32, 33};
    logic [5:0]  ex [4] = '{6'h13, 6'h12, 6'h12, 6'h13};

    bac_regs #(.FAR_WINDOW(WIN)) i_dut
    (
        .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .rssi, .noise_floor, .payload_phase,
        .signal_quality_metric, .energy_detect_flag, .sample_tick, .false_alarm_pulse,
        .dc_comp_en, .loop_lead_coeff, .loop_lag_coeff, .detect_threshold, .acq_detect,
        .verify_pass, .long_preamble_en, .diversity_by_rssi, .scrambler_seed, .status_show_first
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // registers sit on every other index; byte address is four times that
    function automatic logic [31:0] ra(input int i);
        return {22'h0, bac_pkg::IDX_DC_THR + 8'(2 * i), 2'b00};
    endfunction : ra

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= bac_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= bac_pkg::HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    // junk in the upper bits shows they are dropped
    task wr(input int i, input logic [7:0] d);
        bus(1'b1, ra(i), {24'had_beef, d});
    endtask : wr

    task rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk("hrdata", q, exp);
    endtask : rd

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task far_win(input int n);
        for (int i = 0; i < WIN; i++)
        begin
            sample_tick <= 1'b1;
            false_alarm_pulse <= (i < n);
            @(posedge clk);
        end
        sample_tick <= 1'b0;
        false_alarm_pulse <= 1'b0;
        wt(6);
    endtask : far_win

    task give_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, hsel, hwrite, payload_phase, energy_detect_flag, sample_tick} = '0;
        {false_alarm_pulse, haddr, hwdata, rssi, noise_floor, hsize, htrans} = '0;
        signal_quality_metric = 6'h00;
        err_count = 0;
        checks = 0;
        wt(6);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) rd(ra(i), 32'h0000_0000);
        chk("long_preamble_en", long_preamble_en, 1'b1);
        for (int i = 0; i < 11; i++) wr(i, 8'(8'hc3 ^ (i * 8'h1d)));
        for (int i = 0; i < 11; i++) rd(ra(i), {24'h0, 8'(8'hc3 ^ (i * 8'h1d))});
        bus(1'b1, 32'h0000_01fc, 32'h0000_00ff);
        rd(32'h0000_01fc, 32'h0000_0000);
        rd(32'h0000_0142, 32'h0000_0000);
        rd(ra(0), 32'h0000_00c3);
        $display("test readback done");
        wr(0, 8'hc5);
        noise_floor <= 8'h0a;
        rssi <= 8'h0f;
        wt(4);
        chk("dc_comp_en", dc_comp_en, 1'b0);
        rssi <= 8'h10;
        wt(4);
        chk("dc_comp_en", dc_comp_en, 1'b1);
        // sum above 255 must not wrap round
        wr(0, 8'h3f);
        noise_floor <= 8'hf0;
        rssi <= 8'hff;
        wt(4);
        chk("dc_comp_en", dc_comp_en, 1'b0);
        $display("test dc done");
        wr(1, 8'h20);
        wr(2, 8'h01);
        wr(3, 8'h10);
        wr(4, 8'h1f);
        wt(4);
        chk("loop_lead_coeff", loop_lead_coeff, 6'h20);
        chk("loop_lag_coeff", loop_lag_coeff, 6'h01);
        payload_phase <= 1'b1;
        wt(4);
        chk("loop_lead_coeff", loop_lead_coeff, 6'h10);
        chk("loop_lag_coeff", loop_lag_coeff, 6'h1f);
        $display("test coeff done");
        signal_quality_metric <= 6'h18;
        for (int k = 0; k < 4; k++)
        begin
            m = 2'(k);
            wr(6, {m, 6'h18});
            wt(4);
            chk("long_preamble_en", long_preamble_en, !m[1]);
            chk("diversity_by_rssi", diversity_by_rssi, m[0]);
            chk("verify_pass", verify_pass, 1'b1);
        end
        signal_quality_metric <= 6'h17;
        wt(4);
        chk("verify_pass", verify_pass, 1'b0);
        $display("test timeline done");
        wr(7, 8'h90);
        signal_quality_metric <= 6'h10;
        wt(8);
        chk("detect_threshold", detect_threshold, 6'h10);
        chk("acq_detect", acq_detect, 1'b1);
        signal_quality_metric <= 6'h0f;
        wt(4);
        chk("acq_detect", acq_detect, 1'b0);
        signal_quality_metric <= 6'h10;
        wr(7, 8'hd0);
        wt(8);
        chk("acq_detect", acq_detect, 1'b0);
        energy_detect_flag <= 1'b1;
        wt(4);
        chk("acq_detect", acq_detect, 1'b1);
        $display("test acquisition done");
        wr(7, 8'h12);
        wr(5, 8'h01);
        wt(6);
        chk("detect_threshold", detect_threshold, 6'h12);
        // over, under, equal and just over the target of 32 alarms
        for (int j = 0; j < 4; j++)
        begin
            far_win(na[j]);
            chk("detect_threshold", detect_threshold, ex[j]);
        end
        $display("test false alarm done");
        wr(8, 8'h35);
        wr(9, 8'hca);
        wr(10, 8'h00);
        wt(4);
        chk("scrambler_seed", scrambler_seed, 7'h35);
        chk("status_show_first", status_show_first, 1'b1);
        wr(10, 8'h08);
        wt(4);
        chk("scrambler_seed", scrambler_seed, 7'h4a);
        wr(9, 8'h4a);
        wt(4);
        chk("status_show_first", status_show_first, 1'b0);
        $display("test seed done");
        give_verdict;
    end

endmodule : test_bac_regs

`default_nettype wire
